// [ivrc_cfg.svh]
// Purpose: address map, field positions, vector layout and reset values of the
//          interrupt vector and request controller
// Assumes: byte-addressed memory of 20 address bits, 32-bit register port
// Notes:   definitions only
`ifndef IVRC_CFG_SVH
`define IVRC_CFG_SVH

// ************************************************************
// register port map
// ************************************************************
`define IVRC_A_VBASE     12'h000
`define IVRC_A_FLAG      12'h004
`define IVRC_A_EDGE      12'h008
`define IVRC_A_MODE      12'h00C
`define IVRC_A_STAT      12'h010
`define IVRC_A_ICR_BASE  12'h040
`define IVRC_A_CAUSE     12'h35F

// ************************************************************
// field positions and reset values
// ************************************************************
`define IVRC_CFR_IEN     6
`define IVRC_CFR_PLVL_LO 12
`define IVRC_ICR_REQ     3
`define IVRC_CAUSE_B8    6
`define IVRC_CAUSE_B9    7
`define IVRC_MODE_I2C    0
`define IVRC_VBASE_RST   20'h00000
`define IVRC_IPL_TOP     3'h7

// ************************************************************
// vector layout
// ************************************************************
`define IVRC_FIX_BASE    20'hFFFDC
`define IVRC_FIX_TOP     20'hFFFFF
`define IVRC_ALL_ONES    32'hFFFFFFFF
`define IVRC_ENTRY_BYTES 3'h4
`define IVRC_N_BKI       6'h00
`define IVRC_N_FIRST     4
`define IVRC_N_LAST      31
`define IVRC_N_PIN3      4
`define IVRC_N_SIO4      8
`define IVRC_N_SIO3      9
`define IVRC_N_U2TX      15
`define IVRC_N_U2RX      16
`define IVRC_N_INT0      29
`define IVRC_N_SOFT      6'h20

`endif

// [ivrc_pkg.sv]
// Purpose: types shared by the interrupt vector and request controller
// Assumes: ivrc_cfg.svh holds the numbers
// Notes:   fixed kinds are listed in ascending vector address order
package ivrc_pkg;
  typedef enum logic [3:0] {
    IVRC_FIX_UOT  = 4'h0,
    IVRC_FIX_OVF  = 4'h1,
    IVRC_FIX_BKI  = 4'h2,
    IVRC_FIX_AM   = 4'h3,
    IVRC_FIX_SS   = 4'h4,
    IVRC_FIX_WDT  = 4'h5,
    IVRC_FIX_DBG  = 4'h6,
    IVRC_FIX_NMI  = 4'h7,
    IVRC_FIX_RST  = 4'h8
  } ivrc_fix_e;

  typedef enum logic [1:0] {
    IVRC_ST_IDLE   = 2'h0,
    IVRC_ST_FETCH  = 2'h1,
    IVRC_ST_CHECK  = 2'h3,
    IVRC_ST_BRANCH = 2'h2
  } ivrc_state_e;

  typedef logic [19:0] ivrc_addr_t;
endpackage

// [ivrc_top.sv]
// Purpose: interrupt vectoring and request control for the cpu core
// Assumes: all inputs synchronous to ref_clk; vector memory answers a byte read
//          while mem_rd_r stands, so the byte is taken at the edge that ends it
// Notes:   registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps
`include "ivrc_cfg.svh"

module ivrc_top (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic [11:0]         reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire logic [31:0]         periph_evt,
  input  wire logic                sio3_evt,
  input  wire logic                sio4_evt,
  input  wire logic                uart2_tx_evt,
  input  wire logic                uart2_rx_evt,
  input  wire logic                uart2_nack_evt,
  input  wire logic                uart2_ack_evt,
  input  wire logic [5:0]          ext_pin,
  input  wire logic                nmi_n,
  input  wire logic                wdt_evt,
  input  wire logic                debugger_break_irq,
  input  wire logic                trap_req,
  input  wire ivrc_pkg::ivrc_fix_e trap_kind,
  input  wire logic                soft_int_req,
  input  wire logic [5:0]          soft_int_num,
  input  wire logic                cpu_boundary,
  output logic                     mem_rd,
  output ivrc_pkg::ivrc_addr_t     mem_addr,
  input  wire logic [7:0]          mem_rdata,
  output logic                     branch_valid,
  output ivrc_pkg::ivrc_addr_t     branch_addr,
  output logic                     branch_fixed,
  output logic [5:0]               branch_num
);
  import ivrc_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  ivrc_state_e state_r;
  ivrc_addr_t  vbase_r;
  logic        flag_i_r;
  logic [2:0]  proc_lvl_r;
  logic [11:0] edge_sel_r;
  logic        i2c_r;
  logic [1:0]  cause_r;
  logic [2:0]  icr_lvl_r [32];
  logic [31:0] icr_req_r;
  logic [5:0]  pin_q_r;
  logic        nmi_q_r;
  logic        rst_pend_r, nmi_pend_r, dbg_pend_r, wdt_pend_r, trap_pend_r, sw_pend_r;
  ivrc_fix_e   trap_kind_r;
  logic [5:0]  sw_num_r;
  logic        cur_fixed_r, cur_mask_r, redir_r;
  ivrc_fix_e   cur_kind_r;
  logic [5:0]  cur_num_r;
  ivrc_addr_t  fetch_base_r;
  logic [2:0]  issue_cnt_r, cap_cnt_r;
  logic [31:0] vec_word_r;
  logic [31:0] rdata_r;
  logic        mem_rd_r, branch_valid_r, branch_fixed_r;
  ivrc_addr_t  mem_addr_r, branch_addr_r;
  logic [5:0]  branch_num_r;

  assign reg_rdata    = rdata_r;
  assign mem_rd       = mem_rd_r;
  assign mem_addr     = mem_addr_r;
  assign branch_valid = branch_valid_r;
  assign branch_addr  = branch_addr_r;
  assign branch_fixed = branch_fixed_r;
  assign branch_num   = branch_num_r;

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic icr_hit(input logic [11:0] a);
    icr_hit = (a >= (`IVRC_A_ICR_BASE + 12'(`IVRC_N_FIRST))) &&
              (a <= (`IVRC_A_ICR_BASE + 12'(`IVRC_N_LAST)));
  endfunction

  function automatic logic [4:0] icr_idx(input logic [11:0] a);
    icr_idx = 5'(a - `IVRC_A_ICR_BASE);
  endfunction

  function automatic ivrc_addr_t var_entry(input ivrc_addr_t base, input logic [5:0] n);
    var_entry = base + 20'({n, 2'b00});
  endfunction

  // ************************************************************
  // source events
  // ************************************************************
  logic [5:0]  pin_evt;
  logic [31:0] src_evt;
  logic        nmi_fall;

  genvar gp;
  generate
    for (gp = 0; gp < 6; gp++) begin : g_pin
      // synchronous pins, so one stage of history is enough for edges
      assign pin_evt[gp] = (edge_sel_r[2*gp] & ext_pin[gp] & ~pin_q_r[gp]) |
                           (edge_sel_r[2*gp+1] & ~ext_pin[gp] & pin_q_r[gp]);
    end
  endgenerate

  assign nmi_fall = nmi_q_r & ~nmi_n;

  always_comb begin
    src_evt = periph_evt;
    src_evt[3:0] = 4'h0;
    src_evt[`IVRC_N_PIN3] = pin_evt[3];
    src_evt[`IVRC_N_SIO4] = cause_r[0] ? pin_evt[5] : sio4_evt;
    src_evt[`IVRC_N_SIO3] = cause_r[1] ? pin_evt[4] : sio3_evt;
    src_evt[`IVRC_N_U2TX] = i2c_r ? uart2_nack_evt : uart2_tx_evt;
    src_evt[`IVRC_N_U2RX] = i2c_r ? uart2_ack_evt : uart2_rx_evt;
    src_evt[`IVRC_N_INT0]     = pin_evt[0];
    src_evt[`IVRC_N_INT0 + 1] = pin_evt[1];
    src_evt[`IVRC_N_INT0 + 2] = pin_evt[2];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q_r <= 6'h00;
      nmi_q_r <= 1'b1;
    end else begin
      pin_q_r <= ext_pin;
      nmi_q_r <= nmi_n;
    end
  end

  // ************************************************************
  // maskable arbitration
  // ************************************************************
  logic [2:0] best_lvl;
  logic [5:0] best_num;
  logic       mask_ok;

  // ties go to the lowest entry; level 0 never wins so it stays disabled
  always_comb begin
    best_lvl = 3'h0;
    best_num = 6'h00;
    for (int n = `IVRC_N_FIRST; n <= `IVRC_N_LAST; n++) begin
      if (icr_req_r[n] && (icr_lvl_r[n] > best_lvl)) begin
        best_lvl = icr_lvl_r[n];
        best_num = 6'(n);
      end
    end
    mask_ok = flag_i_r && (best_lvl > proc_lvl_r);
  end

  // ************************************************************
  // acceptance
  // ************************************************************
  logic       acc_go, acc_fixed, acc_mask;
  ivrc_fix_e  acc_kind;
  logic [5:0] acc_num;

  // non-maskable sources ahead of the mask test, which never sees them
  always_comb begin
    acc_go    = (state_r == IVRC_ST_IDLE) && (cpu_boundary || rst_pend_r);
    acc_fixed = 1'b1;
    acc_mask  = 1'b0;
    acc_kind  = IVRC_FIX_RST;
    acc_num   = 6'h00;
    if (rst_pend_r) begin
      acc_kind = IVRC_FIX_RST;
    end else if (nmi_pend_r) begin
      acc_kind = IVRC_FIX_NMI;
    end else if (dbg_pend_r) begin
      acc_kind = IVRC_FIX_DBG;
    end else if (wdt_pend_r) begin
      acc_kind = IVRC_FIX_WDT;
    end else if (trap_pend_r) begin
      acc_kind = trap_kind_r;
    end else if (sw_pend_r) begin
      acc_fixed = 1'b0;
      acc_num   = sw_num_r;
    end else if (mask_ok) begin
      acc_fixed = 1'b0;
      acc_mask  = 1'b1;
      acc_num   = best_num;
    end else begin
      acc_go = 1'b0;
    end
  end

  // ************************************************************
  // pending non-maskable requests; a new event beats the clear
  // ************************************************************
  logic take_fix;
  assign take_fix = acc_go && acc_fixed;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pend_r  <= 1'b1;
      nmi_pend_r  <= 1'b0;
      dbg_pend_r  <= 1'b0;
      wdt_pend_r  <= 1'b0;
      trap_pend_r <= 1'b0;
      sw_pend_r   <= 1'b0;
      trap_kind_r <= IVRC_FIX_UOT;
      sw_num_r    <= 6'h00;
    end else begin
      if (take_fix && acc_kind == IVRC_FIX_RST) rst_pend_r <= 1'b0;
      nmi_pend_r <= nmi_fall | (nmi_pend_r & ~(take_fix && acc_kind == IVRC_FIX_NMI));
      dbg_pend_r <= debugger_break_irq | (dbg_pend_r & ~(take_fix && acc_kind == IVRC_FIX_DBG));
      wdt_pend_r <= wdt_evt | (wdt_pend_r & ~(take_fix && acc_kind == IVRC_FIX_WDT));
      trap_pend_r <= trap_req | (trap_pend_r & ~(take_fix && !rst_pend_r && !nmi_pend_r &&
                                                 !dbg_pend_r && !wdt_pend_r));
      sw_pend_r <= soft_int_req | (sw_pend_r & ~(acc_go && !acc_fixed && !acc_mask));
      if (trap_req) trap_kind_r <= trap_kind;
      if (soft_int_req) sw_num_r <= soft_int_num;
    end
  end

  // ************************************************************
  // vector fetch sequencer
  // ************************************************************
  logic bki_all_ones;
  assign bki_all_ones = cur_fixed_r && (cur_kind_r == IVRC_FIX_BKI) && !redir_r &&
                        (vec_word_r == `IVRC_ALL_ONES);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r        <= IVRC_ST_IDLE;
      cur_fixed_r    <= 1'b0;
      cur_mask_r     <= 1'b0;
      cur_kind_r     <= IVRC_FIX_RST;
      cur_num_r      <= 6'h00;
      redir_r        <= 1'b0;
      fetch_base_r   <= `IVRC_VBASE_RST;
      branch_valid_r <= 1'b0;
      branch_addr_r  <= `IVRC_VBASE_RST;
      branch_fixed_r <= 1'b0;
      branch_num_r   <= 6'h00;
    end else begin
      branch_valid_r <= 1'b0;
      case (state_r)
        IVRC_ST_IDLE: begin
          if (acc_go) begin
            state_r     <= IVRC_ST_FETCH;
            cur_fixed_r <= acc_fixed;
            cur_mask_r  <= acc_mask;
            cur_kind_r  <= acc_kind;
            cur_num_r   <= acc_num;
            redir_r     <= 1'b0;
            fetch_base_r <= acc_fixed ?
                            (`IVRC_FIX_BASE + 20'({acc_kind, 2'b00})) :
                            var_entry(vbase_r, acc_num);
          end
        end
        IVRC_ST_FETCH: begin
          if (mem_rd_r && cap_cnt_r == (`IVRC_ENTRY_BYTES - 3'h1)) state_r <= IVRC_ST_CHECK;
        end
        IVRC_ST_CHECK: begin
          if (bki_all_ones) begin
            state_r      <= IVRC_ST_FETCH;
            redir_r      <= 1'b1;
            fetch_base_r <= var_entry(vbase_r, `IVRC_N_BKI);
          end else begin
            state_r <= IVRC_ST_BRANCH;
          end
        end
        IVRC_ST_BRANCH: begin
          state_r        <= IVRC_ST_IDLE;
          branch_valid_r <= 1'b1;
          branch_addr_r  <= vec_word_r[19:0];
          branch_fixed_r <= cur_fixed_r && !redir_r;
          branch_num_r   <= redir_r ? `IVRC_N_BKI : cur_num_r;
        end
        default: state_r <= IVRC_ST_IDLE;
      endcase
    end
  end

  // four byte reads issued back to back, each answered one cycle later
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      issue_cnt_r <= 3'h0;
      cap_cnt_r   <= 3'h0;
      mem_rd_r    <= 1'b0;
      mem_addr_r  <= `IVRC_VBASE_RST;
      vec_word_r  <= 32'h00000000;
    end else begin
      mem_rd_r <= 1'b0;
      if (state_r == IVRC_ST_FETCH && issue_cnt_r != `IVRC_ENTRY_BYTES) begin
        mem_rd_r    <= 1'b1;
        mem_addr_r  <= fetch_base_r + 20'(issue_cnt_r);
        issue_cnt_r <= issue_cnt_r + 3'h1;
      end else if (state_r != IVRC_ST_FETCH) begin
        issue_cnt_r <= 3'h0;
      end
      if (mem_rd_r) begin
        vec_word_r[{cap_cnt_r[1:0], 3'b000} +: 8] <= mem_rdata;
        cap_cnt_r <= cap_cnt_r + 3'h1;
      end else if (state_r != IVRC_ST_FETCH) begin
        cap_cnt_r <= 3'h0;
      end
    end
  end

  // ************************************************************
  // registers written by software
  // ************************************************************
  logic wr_icr;
  assign wr_icr = reg_wr && icr_hit(reg_addr);

  // acceptance outranks a same-cycle software write of the flag register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_i_r <= 1'b0;
      proc_lvl_r <= 3'h0;
    end else if (acc_go) begin
      flag_i_r <= 1'b0;
      if (acc_mask) proc_lvl_r <= best_lvl;
    end else if (reg_wr && reg_addr == `IVRC_A_FLAG) begin
      flag_i_r   <= reg_wdata[`IVRC_CFR_IEN];
      proc_lvl_r <= reg_wdata[`IVRC_CFR_PLVL_LO +: 3];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vbase_r    <= `IVRC_VBASE_RST;
      edge_sel_r <= 12'h000;
      i2c_r      <= 1'b0;
      cause_r    <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == `IVRC_A_VBASE) vbase_r <= reg_wdata[19:0];
      if (reg_addr == `IVRC_A_EDGE) edge_sel_r <= reg_wdata[11:0];
      if (reg_addr == `IVRC_A_MODE) i2c_r <= reg_wdata[`IVRC_MODE_I2C];
      if (reg_addr == `IVRC_A_CAUSE) begin
        cause_r <= {reg_wdata[`IVRC_CAUSE_B9], reg_wdata[`IVRC_CAUSE_B8]};
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_icr
      if (gi >= `IVRC_N_FIRST && gi <= `IVRC_N_LAST) begin : g_src
        logic sw_clr, hw_clr;
        assign sw_clr = wr_icr && icr_idx(reg_addr) == 5'(gi) &&
                        !reg_wdata[`IVRC_ICR_REQ];
        assign hw_clr = state_r == IVRC_ST_BRANCH && cur_mask_r &&
                        cur_num_r == 6'(gi);
        always_ff @(posedge ref_clk or negedge rst_n) begin
          if (!rst_n) begin
            icr_req_r[gi] <= 1'b0;
            icr_lvl_r[gi] <= 3'h0;
          end else begin
            // an event in the clearing cycle survives
            icr_req_r[gi] <= src_evt[gi] | (icr_req_r[gi] & ~sw_clr & ~hw_clr);
            if (wr_icr && icr_idx(reg_addr) == 5'(gi)) begin
              icr_lvl_r[gi] <= reg_wdata[2:0];
            end
          end
        end
      end else begin : g_none
        assign icr_req_r[gi] = 1'b0;
        assign icr_lvl_r[gi] = 3'h0;
      end
    end
  endgenerate

  // ************************************************************
  // read port; unmapped addresses read zero
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (reg_rd) begin
      rdata_r <= 32'h00000000;
      if (reg_addr == `IVRC_A_VBASE) rdata_r[19:0] <= vbase_r;
      if (reg_addr == `IVRC_A_FLAG) begin
        rdata_r[`IVRC_CFR_IEN] <= flag_i_r;
        rdata_r[`IVRC_CFR_PLVL_LO +: 3] <= proc_lvl_r;
      end
      if (reg_addr == `IVRC_A_EDGE) rdata_r[11:0] <= edge_sel_r;
      if (reg_addr == `IVRC_A_MODE) rdata_r[`IVRC_MODE_I2C] <= i2c_r;
      if (reg_addr == `IVRC_A_CAUSE) begin
        rdata_r[`IVRC_CAUSE_B8] <= cause_r[0];
        rdata_r[`IVRC_CAUSE_B9] <= cause_r[1];
      end
      if (reg_addr == `IVRC_A_STAT) rdata_r[9:0] <= {state_r, cur_num_r, cur_fixed_r, redir_r};
      if (icr_hit(reg_addr)) begin
        rdata_r[2:0] <= icr_lvl_r[icr_idx(reg_addr)];
        rdata_r[`IVRC_ICR_REQ] <= icr_req_r[icr_idx(reg_addr)];
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_four_reads;
    mem_rd_r [*4] ##1 !mem_rd_r;
  endsequence

  sequence s_redirect;
    state_r == IVRC_ST_FETCH ##1 mem_addr_r == $past(vbase_r);
  endsequence

  a_req_hw_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((icr_req_r & ~$past(icr_req_r) & ~$past(src_evt)) == 32'h0))
    else $error("request bit set without its source event");

  a_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    acc_go && acc_mask |-> flag_i_r && best_lvl > proc_lvl_r && best_lvl != 3'h0)
    else $error("maskable accepted while gated");

  a_enable_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    acc_go |=> !flag_i_r && state_r == IVRC_ST_FETCH)
    else $error("enable flag not cleared on accept");

  a_fetch_four: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(state_r == IVRC_ST_FETCH) |=> s_four_reads)
    else $error("vector fetch is not four reads");

  a_nmi_vector: assert property (@(posedge ref_clk) disable iff (!rst_n)
    acc_go && acc_fixed && acc_kind == IVRC_FIX_NMI
    |-> ##2 mem_addr_r == (`IVRC_FIX_BASE + 20'({IVRC_FIX_NMI, 2'b00})))
    else $error("nmi fetch address wrong");

  a_break_redirect: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == IVRC_ST_CHECK && bki_all_ones |=> s_redirect)
    else $error("break redirect not taken");

  a_req_cleared: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == IVRC_ST_BRANCH && cur_mask_r && !src_evt[cur_num_r[4:0]]
    |=> !icr_req_r[$past(cur_num_r[4:0])] && branch_valid_r)
    else $error("request bit not cleared at branch");

  a_soft_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == IVRC_ST_IDLE && cpu_boundary && sw_pend_r |=> state_r == IVRC_ST_FETCH)
    else $error("software interrupt blocked");

  a_nmi_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    nmi_q_r && !nmi_n |=> nmi_pend_r)
    else $error("nmi edge lost");
endmodule

// [ivrc_top_tb.sv]
// Purpose: self-checking bench of the vector and request controller
// Assumes: cpu_boundary held high; vector memory is ivrc_vmem
// Notes:   sources are only stirred while their control is not rewritten
`timescale 1ns/1ps

module ivrc_top_tb;
  import ivrc_pkg::*;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sio3_evt = 0, sio4_evt = 0;
  logic uart2_tx_evt = 0, uart2_rx_evt = 0, uart2_nack_evt = 0, uart2_ack_evt = 0;
  logic nmi_n = 1, wdt_evt = 0, dbg = 0, trap_req = 0, soft_int_req = 0, bki_ones = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, periph_evt = 32'h0, d;
  logic [5:0]  ext_pin = 6'h00, soft_int_num = 6'h00, branch_num;
  ivrc_fix_e   trap_kind = IVRC_FIX_UOT;
  ivrc_addr_t  mem_addr, branch_addr;
  logic        mem_rd, branch_valid, branch_fixed;
  logic [7:0]  mem_rdata;
  int          failures = 0, n_compared = 0;
  localparam ivrc_addr_t VB = 20'h10000;

  ivrc_top i_ivrc_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .periph_evt(periph_evt), .sio3_evt(sio3_evt), .sio4_evt(sio4_evt),
    .uart2_tx_evt(uart2_tx_evt), .uart2_rx_evt(uart2_rx_evt),
    .uart2_nack_evt(uart2_nack_evt), .uart2_ack_evt(uart2_ack_evt), .ext_pin(ext_pin),
    .nmi_n(nmi_n), .wdt_evt(wdt_evt), .debugger_break_irq(dbg), .trap_req(trap_req),
    .trap_kind(trap_kind), .soft_int_req(soft_int_req), .soft_int_num(soft_int_num),
    .cpu_boundary(1'b1), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .branch_valid(branch_valid), .branch_addr(branch_addr),
    .branch_fixed(branch_fixed), .branch_num(branch_num));
  ivrc_vmem i_ivrc_vmem (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .bki_ones(bki_ones), .mem_rdata(mem_rdata));

  // ************************************************************
  // tasks
  // ************************************************************
  initial forever #10 ref_clk = ~ref_clk;
  function automatic ivrc_addr_t exp_at(input ivrc_addr_t b);
    logic [7:0] b2;
    b2 = b[7:0] + 8'h13;
    return {b2[3:0], b[7:0] + 8'h12, b[7:0] + 8'h11};
  endfunction
  task automatic summarize();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
    @(posedge ref_clk); reg_wr <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk); reg_rd <= 1; reg_addr <= a;
    @(posedge ref_clk); reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_br(input ivrc_addr_t e, input logic f, input logic [5:0] n);
    int i;
    // step past an edge first, so a branch pulse still standing is not taken twice
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      #1;
      if (branch_valid === 1'b1) break;
    end
    if (i == 60) begin
      failures++;
      summarize();
    end else begin
      cmp(32'(branch_addr), 32'(e));
      cmp(32'(branch_fixed), 32'(f));
      if (!f) cmp(32'(branch_num), 32'(n));
    end
  endtask
  task automatic quiet(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge ref_clk); #1;
      if (branch_valid === 1'b1) k++;
    end
    cmp(k, 0);
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1;
    wait_br(exp_at(20'hFFFFC), 1, 0);
    rd(12'h004); cmp(d, 32'h0);
    rd(12'h100); cmp(d, 32'h0);
    wr(12'h000, 32'(VB));
    wr(12'h055, 32'h3);
    @(posedge ref_clk); periph_evt[21] <= 1;
    @(posedge ref_clk); periph_evt[21] <= 0;
    rd(12'h055); cmp(d, 32'hB);
    quiet(10);
    wr(12'h004, 32'h3040); quiet(10);
    wr(12'h004, 32'h2040);
    wait_br(exp_at(VB + 84), 0, 21);
    rd(12'h055); cmp(d, 32'h3);
    wr(12'h055, 32'hF); rd(12'h055); cmp(d, 32'h7);
    wr(12'h004, 32'h7040);
    @(posedge ref_clk); periph_evt[21] <= 1;
    @(posedge ref_clk); periph_evt[21] <= 0;
    quiet(10);
    wr(12'h055, 32'h7); wr(12'h004, 32'h0040); quiet(10);
    wr(12'h004, 32'h0);
    @(posedge ref_clk); soft_int_req <= 1; soft_int_num <= 6'h28;
    @(posedge ref_clk); soft_int_req <= 0;
    wait_br(exp_at(VB + 160), 0, 40);
    @(posedge ref_clk); bki_ones <= 1; trap_req <= 1; trap_kind <= IVRC_FIX_BKI;
    @(posedge ref_clk); trap_req <= 0;
    wait_br(exp_at(VB), 0, 0);
    @(posedge ref_clk); nmi_n <= 0;
    wait_br(exp_at(20'hFFFF8), 1, 0);
    @(posedge ref_clk); dbg <= 1; wdt_evt <= 1;
    @(posedge ref_clk); dbg <= 0; wdt_evt <= 0;
    wait_br(exp_at(20'hFFFF4), 1, 0);
    wait_br(exp_at(20'hFFFF0), 1, 0);
    wr(12'h008, 32'h401); wr(12'h05D, 32'h2); wr(12'h004, 32'h40);
    @(posedge ref_clk); ext_pin[0] <= 1;
    wait_br(exp_at(VB + 116), 0, 29);
    wr(12'h00C, 32'h1); wr(12'h04F, 32'h1); wr(12'h004, 32'h40);
    @(posedge ref_clk); uart2_nack_evt <= 1;
    @(posedge ref_clk); uart2_nack_evt <= 0;
    wait_br(exp_at(VB + 60), 0, 15);
    wr(12'h35F, 32'h40); wr(12'h048, 32'h1); wr(12'h004, 32'h40);
    @(posedge ref_clk); ext_pin[5] <= 1;
    wait_br(exp_at(VB + 32), 0, 8);
    wr(12'h008, 32'h402); wr(12'h004, 32'h40);
    @(posedge ref_clk); ext_pin[0] <= 0;
    wait_br(exp_at(VB + 116), 0, 29);
    summarize();
  end
endmodule

// [ivrc_vmem.sv]
// Purpose: vector memory answering the controller's byte fetches
// Assumes: the byte answers while mem_rd stands, with no delay of its own
// Notes:   each byte is its address low byte plus 8'h11, or 8'hFF in the break entry while bki_ones is set
`timescale 1ns/1ps

module ivrc_vmem (
  input  wire logic        ref_clk,
  input  wire logic        mem_rd,
  input  wire logic [19:0] mem_addr,
  input  wire logic        bki_ones,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] byte_val;

  // ************************************************************
  // byte answer
  // ************************************************************
  // the controller takes the byte at the edge that ends its read cycle,
  // so the answer follows the address at once
  always_comb begin
    byte_val = mem_addr[7:0] + 8'h11;
    if (bki_ones && mem_addr[19:2] == 18'h3FFF9) begin
      byte_val = 8'hFF;
    end
    // outside a read the line shows the inverse, so a stale byte never looks like data
    mem_rdata = mem_rd ? byte_val : ~byte_val;
  end
endmodule
